/* shared/sgp_pkg.sv */
// sgp_pkg: register map, field layout and carrier types of the shared gpio ports e, f and g
// assumes an 8-bit register port with byte offsets; direction offsets are coined
package sgp_pkg;

	localparam int SGP_ADDR_W = 8;
	localparam int SGP_DATA_W = 8;
	localparam int SGP_PE_W = 8;
	localparam int SGP_PF_W = 6;
	localparam int SGP_PG_W = 4;

	// register offsets
	localparam logic [7:0] SGP_OFS_PORT_E_DATA = 8'h08;
	localparam logic [7:0] SGP_OFS_PORT_F_DATA = 8'h09;
	localparam logic [7:0] SGP_OFS_PORT_G_DATA = 8'h0A;
	localparam logic [7:0] SGP_OFS_PORT_E_DIR = 8'h0C;
	localparam logic [7:0] SGP_OFS_PORT_F_DIR = 8'h0D;
	localparam logic [7:0] SGP_OFS_PORT_G_DIR = 8'h0E;

	// reset values
	localparam logic [7:0] SGP_RST_PORT_E_DIR = 8'h00;
	localparam logic [5:0] SGP_RST_PORT_F_DIR = 6'h00;
	localparam logic [3:0] SGP_RST_PORT_G_DIR = 4'h0;
	localparam logic [7:0] SGP_RST_READ = 8'h00;

	// port e pin positions
	localparam int SGP_PE_TCH_LO = 4;
	localparam int SGP_PE_TIMER_EXTERNAL_CLOCK = 3;
	localparam int SGP_PE_TXD = 2;
	localparam int SGP_PE_RXD = 1;
	// port f pin positions
	localparam int SGP_PF_MISO = 3;
	localparam int SGP_PF_MOSI = 2;
	localparam int SGP_PF_SPSCK = 1;
	localparam int SGP_PF_SS = 0;

	// prescaler code that picks the external timer clock
	localparam logic [2:0] SGP_PS_EXT_CLK = 3'h7;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sgp_bus_req_t;

	// peripheral claims and drive values
	typedef struct packed {
		logic [3:0] tch_own;
		logic [3:0] tch_out_en;
		logic [3:0] tch_out;
		logic [2:0] timer_prescaler_select;
		logic serial_unit_enable;
		logic serial_txd;
		logic spi_unit_enable;
		logic spi_master_select;
		logic [2:0] spi_out_en;
		logic [2:0] spi_out;
	} sgp_periph_t;

endpackage

/* rtl/sgp_ports.sv */
// sgp_ports: data latches, direction registers and pin muxing for ports e, f and g
// assumes a single-cycle register port on clk_sys and pins from off chip
//
// Summary of operation
// [R1] port e eight pins, port f six, port g four, each with latch and direction
// [R2] direction one drives latch onto pin; zero leaves pin as high-impedance input
// [R3] every reset clears all direction bits so every pin starts as input
// [R4] port e data read returns latch where direction one, pin where zero
// [R5] port f data read returns latch where direction one, pin where zero
// [R6] port g data read returns latch where direction one, pin where zero
// [R7] data writes always update the latches regardless of direction
// [R8] writing an input pin's data bit changes only the latch, not pin readback
// [R9] reset leaves port f and port g latches unchanged
// [R10] port e pins 7..4 are timer channels 3..0 when claimed, else gpio
// [R11] peripheral-owned pins ignore direction for drive; direction still picks readback
// [R12] port e pin 3 feeds timer external clock when prescaler selects it
// [R13] port e pin 2 carries serial transmit while serial enable set
// [R14] port e pin 1 feeds serial receive while serial enable set
// [R15] with spi enabled port f pins 3,2,1 carry miso, mosi, spsck
// [R16] port f pin 0 is slave select unless spi disabled or master mode
// [R17] with spi enabled direction bit zero of port f has no effect on slave select
// [R18] software should load latch before raising a direction bit
// [R19] pin levels pass a two-stage synchroniser before readback
`timescale 1ns/10ps

module sgp_ports
	import sgp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire sgp_bus_req_t bus_req,
	output logic [7:0] rdata,
	// peripheral side
	input wire sgp_periph_t periph,
	output logic [3:0] tch_in,
	output logic timer_external_clock,
	output logic serial_rxd,
	output logic [2:0] spi_in,
	output logic spi_slave_select_n,
	// port e pins
	input wire logic [SGP_PE_W-1:0] pe_in,
	output logic [SGP_PE_W-1:0] pe_out,
	output logic [SGP_PE_W-1:0] pe_oe,
	// port f pins
	input wire logic [SGP_PF_W-1:0] pf_in,
	output logic [SGP_PF_W-1:0] pf_out,
	output logic [SGP_PF_W-1:0] pf_oe,
	// port g pins
	input wire logic [SGP_PG_W-1:0] pg_in,
	output logic [SGP_PG_W-1:0] pg_out,
	output logic [SGP_PG_W-1:0] pg_oe
);

	logic [SGP_PE_W-1:0] port_e_data_latch;
	logic [SGP_PF_W-1:0] port_f_data_latch;
	logic [SGP_PG_W-1:0] port_g_data_latch;
	logic [SGP_PE_W-1:0] port_e_direction;
	logic [SGP_PF_W-1:0] port_f_direction;
	logic [SGP_PG_W-1:0] port_g_direction;
	logic [SGP_PE_W-1:0] pe_meta;
	logic [SGP_PE_W-1:0] pe_sync;
	logic [SGP_PF_W-1:0] pf_meta;
	logic [SGP_PF_W-1:0] pf_sync;
	logic [SGP_PG_W-1:0] pg_meta;
	logic [SGP_PG_W-1:0] pg_sync;
	logic [SGP_PE_W-1:0] pe_own;
	logic [SGP_PE_W-1:0] pe_pval;
	logic [SGP_PE_W-1:0] pe_poe;
	logic [SGP_PF_W-1:0] pf_own;
	logic [SGP_PF_W-1:0] pf_pval;
	logic [SGP_PF_W-1:0] pf_poe;
	logic [7:0] next_rdata;
	logic [SGP_PE_W-1:0] next_pe_out;
	logic [SGP_PE_W-1:0] next_pe_oe;
	logic [SGP_PF_W-1:0] next_pf_out;
	logic [SGP_PF_W-1:0] next_pf_oe;
	logic spi_slave_owns;
	logic timer_external_clock_picked;
	// wide working copies of the port f drive
	logic [7:0] pf_out_wide;
	logic [7:0] pf_oe_wide;
	// port g has no peripheral, its pads follow the registers
	logic [SGP_PG_W-1:0] next_pg_out;
	logic [SGP_PG_W-1:0] next_pg_oe;
	// next values of the peripheral feeds
	logic [3:0] next_tch_in;
	logic next_timer_external_clock;
	logic next_serial_rxd;
	logic [2:0] next_spi_in;
	logic next_spi_slave_select_n;
	// per-port readback
	logic [7:0] rd_port_e;
	logic [7:0] rd_port_f;
	logic [7:0] rd_port_g;

	// per-bit readback choice shared by all three ports
	function automatic logic [7:0] read_mux(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] pin);
		read_mux = (latch & dir) | (pin & ~dir);
	endfunction

	// per-bit pick between a peripheral and the port registers
	function automatic logic [7:0] own_mux(input logic [7:0] own, input logic [7:0] by_periph,
		input logic [7:0] by_port);
		own_mux = (own & by_periph) | (~own & by_port);
	endfunction

	// write strobe aimed at one offset
	function automatic logic wr_hit(input sgp_bus_req_t r, input logic [7:0] ofs);
		wr_hit = r.wr && (r.addr == ofs);
	endfunction

	// narrow ports read zero in their unused upper bits
	function automatic logic [7:0] widen_f(input logic [SGP_PF_W-1:0] v);
		widen_f = {{(8-SGP_PF_W){1'h0}}, v};
	endfunction

	function automatic logic [7:0] widen_g(input logic [SGP_PG_W-1:0] v);
		widen_g = {{(8-SGP_PG_W){1'h0}}, v};
	endfunction

	// port e synchroniser; first stage feeds only the second
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pe_meta <= '0;
			pe_sync <= '0;
		end else begin
			pe_meta <= pe_in; // R19
			pe_sync <= pe_meta; // R19
		end
	end

	// port f synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pf_meta <= '0;
			pf_sync <= '0;
		end else begin
			pf_meta <= pf_in; // R19
			pf_sync <= pf_meta; // R19
		end
	end

	// port g synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pg_meta <= '0;
			pg_sync <= '0;
		end else begin
			pg_meta <= pg_in; // R19
			pg_sync <= pg_meta; // R19
		end
	end

	// latches have no reset: they keep their value across reset
	always_ff @(posedge clk_sys) begin
		if (wr_hit(bus_req, SGP_OFS_PORT_E_DATA)) begin
			port_e_data_latch <= bus_req.wdata; // R7 R8
		end
	end

	// port f latch
	always_ff @(posedge clk_sys) begin
		if (wr_hit(bus_req, SGP_OFS_PORT_F_DATA)) begin
			port_f_data_latch <= bus_req.wdata[SGP_PF_W-1:0]; // R7 R8 R9
		end
	end

	// port g latch
	always_ff @(posedge clk_sys) begin
		if (wr_hit(bus_req, SGP_OFS_PORT_G_DATA)) begin
			port_g_data_latch <= bus_req.wdata[SGP_PG_W-1:0]; // R7 R8 R9
		end
	end

	// port e direction
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			port_e_direction <= SGP_RST_PORT_E_DIR; // R3
		end else if (wr_hit(bus_req, SGP_OFS_PORT_E_DIR)) begin
			port_e_direction <= bus_req.wdata; // R1
		end
	end

	// port f direction
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			port_f_direction <= SGP_RST_PORT_F_DIR; // R3
		end else if (wr_hit(bus_req, SGP_OFS_PORT_F_DIR)) begin
			port_f_direction <= bus_req.wdata[SGP_PF_W-1:0]; // R1
		end
	end

	// port g direction
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			port_g_direction <= SGP_RST_PORT_G_DIR; // R3
		end else if (wr_hit(bus_req, SGP_OFS_PORT_G_DIR)) begin
			port_g_direction <= bus_req.wdata[SGP_PG_W-1:0]; // R1
		end
	end

	// prescaler pick of the external timer clock, used by ownership and feed
	always_comb begin
		timer_external_clock_picked = (periph.timer_prescaler_select == SGP_PS_EXT_CLK); // R12
	end

	// peripheral ownership of port e
	always_comb begin
		pe_own = '0;
		pe_pval = '0;
		pe_poe = '0;
		pe_own[SGP_PE_W-1:SGP_PE_TCH_LO] = periph.tch_own; // R10
		pe_pval[SGP_PE_W-1:SGP_PE_TCH_LO] = periph.tch_out; // R10
		pe_poe[SGP_PE_W-1:SGP_PE_TCH_LO] = periph.tch_out_en; // R10
		// external clock pin stays an input while selected
		pe_own[SGP_PE_TIMER_EXTERNAL_CLOCK] = timer_external_clock_picked; // R12
		pe_own[SGP_PE_TXD] = periph.serial_unit_enable; // R13
		pe_pval[SGP_PE_TXD] = periph.serial_txd; // R13
		pe_poe[SGP_PE_TXD] = periph.serial_unit_enable; // R13
		pe_own[SGP_PE_RXD] = periph.serial_unit_enable; // R14
	end

	// peripheral ownership of port f
	always_comb begin
		spi_slave_owns = periph.spi_unit_enable && !periph.spi_master_select; // R16
		pf_own = '0;
		pf_pval = '0;
		pf_poe = '0;
		pf_own[SGP_PF_MISO:SGP_PF_SPSCK] = {3{periph.spi_unit_enable}}; // R15
		pf_pval[SGP_PF_MISO:SGP_PF_SPSCK] = periph.spi_out; // R15
		pf_poe[SGP_PF_MISO:SGP_PF_SPSCK] = periph.spi_out_en & {3{periph.spi_unit_enable}}; // R15
		// pin 0 driver stays off whenever spi is on, even in master mode
		pf_own[SGP_PF_SS] = periph.spi_unit_enable; // R17
	end

	// pin drive: direction only where no peripheral owns the pin
	always_comb begin
		next_pe_out = own_mux(pe_own, pe_pval, port_e_data_latch); // R2
		next_pe_oe = own_mux(pe_own, pe_poe, port_e_direction); // R2 R11
		pf_out_wide = own_mux(widen_f(pf_own), widen_f(pf_pval),
			widen_f(port_f_data_latch)); // R2
		pf_oe_wide = own_mux(widen_f(pf_own), widen_f(pf_poe),
			widen_f(port_f_direction)); // R2 R11 R17
		next_pf_out = pf_out_wide[SGP_PF_W-1:0];
		next_pf_oe = pf_oe_wide[SGP_PF_W-1:0];
		// no peripheral on port g: direction alone decides
		next_pg_out = port_g_data_latch; // R2
		next_pg_oe = port_g_direction; // R2
	end

	// port e pads; registered so enables never glitch, at one cycle of latency
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pe_out <= '0;
			pe_oe <= '0;
		end else begin
			pe_out <= next_pe_out;
			pe_oe <= next_pe_oe; // R2
		end
	end

	// port f pads
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pf_out <= '0;
			pf_oe <= '0;
		end else begin
			pf_out <= next_pf_out;
			pf_oe <= next_pf_oe; // R2
		end
	end

	// port g pads
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pg_out <= '0;
			pg_oe <= '0;
		end else begin
			pg_out <= next_pg_out; // R2
			pg_oe <= next_pg_oe; // R2
		end
	end

	// synchronised pin levels toward peripherals, gated by ownership
	always_comb begin
		next_tch_in = pe_sync[SGP_PE_W-1:SGP_PE_TCH_LO] & periph.tch_own; // R10
		next_timer_external_clock = pe_sync[SGP_PE_TIMER_EXTERNAL_CLOCK] & timer_external_clock_picked; // R12
		next_serial_rxd = periph.serial_unit_enable ? pe_sync[SGP_PE_RXD] : 1'b1; // R14
		next_spi_in = periph.spi_unit_enable ? pf_sync[SGP_PF_MISO:SGP_PF_SPSCK] : 3'h0; // R15
		next_spi_slave_select_n = spi_slave_owns ? pf_sync[SGP_PF_SS] : 1'b1; // R16
	end

	// timer feeds read low while their pins are not claimed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tch_in <= '0;
			timer_external_clock <= 1'b0;
		end else begin
			tch_in <= next_tch_in; // R10
			timer_external_clock <= next_timer_external_clock; // R12
		end
	end

	// receive idles high so a disabled receiver never sees a start bit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			serial_rxd <= 1'b1;
		end else begin
			serial_rxd <= next_serial_rxd; // R14
		end
	end

	// spi feeds; select idles high, that is not selected
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			spi_in <= '0;
			spi_slave_select_n <= 1'b1;
		end else begin
			spi_in <= next_spi_in; // R15
			spi_slave_select_n <= next_spi_slave_select_n; // R16
		end
	end

	// per-port readback; direction always picks latch or pin, ownership aside
	always_comb begin
		rd_port_e = read_mux(port_e_data_latch, port_e_direction, pe_sync); // R4 R11
		rd_port_f = read_mux(widen_f(port_f_data_latch), widen_f(port_f_direction),
			widen_f(pf_sync)); // R5 R11
		rd_port_g = read_mux(widen_g(port_g_data_latch), widen_g(port_g_direction),
			widen_g(pg_sync)); // R6
	end

	// read decode; idle cycles and unmapped offsets return zero
	always_comb begin
		next_rdata = SGP_RST_READ;
		if (bus_req.rd) begin
			case (bus_req.addr)
				SGP_OFS_PORT_E_DATA: begin
					next_rdata = rd_port_e; // R4
				end
				SGP_OFS_PORT_F_DATA: begin
					next_rdata = rd_port_f; // R5
				end
				SGP_OFS_PORT_G_DATA: begin
					next_rdata = rd_port_g; // R6
				end
				// direction registers read back as written
				SGP_OFS_PORT_E_DIR: begin
					next_rdata = port_e_direction;
				end
				SGP_OFS_PORT_F_DIR: begin
					next_rdata = widen_f(port_f_direction);
				end
				SGP_OFS_PORT_G_DIR: begin
					next_rdata = widen_g(port_g_direction);
				end
				default: begin
					next_rdata = SGP_RST_READ;
				end
			endcase
		end
	end

	// read data holds only for the cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= SGP_RST_READ;
		end else begin
			rdata <= next_rdata;
		end
	end

endmodule // sgp_ports

/* dv/sgp_pins_model.sv */
// sgp_pins_model: board side of one port
// assumes oe high while the port drives a pin; no pull resistors
`timescale 1ns/10ps
module sgp_pins_model #(parameter int W = 8) (
	// port side
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	// board side
	input wire logic [W-1:0] ext,
	output logic [W-1:0] pin_in
);
	// driven bits show the port value, the rest the board level
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // sgp_pins_model

/* dv/sgp_ports_monitor.sv */
// sgp_ports_monitor: port-level assertions for sgp_ports
// assumes one clock domain; bound to every sgp_ports instance
`timescale 1ns/10ps
module sgp_ports_monitor
	import sgp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus and peripherals
	input wire sgp_bus_req_t bus_req,
	input wire logic [7:0] rdata,
	input wire sgp_periph_t periph,
	input wire logic timer_external_clock,
	input wire logic serial_rxd,
	input wire logic [2:0] spi_in,
	input wire logic spi_slave_select_n,
	// pins
	input wire logic [7:0] pe_out,
	input wire logic [7:0] pe_oe,
	input wire logic [5:0] pf_oe,
	input wire logic [3:0] pg_out,
	input wire logic [3:0] pg_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_dir_cleared: assert property ($fell(rst) |-> pe_oe == 8'h00 && pf_oe == 6'h00 && pg_oe == 4'h0)
		else $error("oe set after reset");
	a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("rdata without read");
	a_g_dir_drive: assert property (bus_req.wr && bus_req.addr == SGP_OFS_PORT_G_DIR |->
		##2 pg_oe == $past(bus_req.wdata[3:0], 2)) else $error("port g oe wrong");
	a_g_latch_out: assert property (bus_req.wr && bus_req.addr == SGP_OFS_PORT_G_DATA |->
		##2 ((pg_out ^ $past(bus_req.wdata[3:0], 2)) & pg_oe) == 4'h0) else $error("port g out");
	a_ss_undriven: assert property (periph.spi_unit_enable |=> !pf_oe[SGP_PF_SS])
		else $error("slave select driven");
	a_tx_drive: assert property (periph.serial_unit_enable |=> pe_oe[SGP_PE_TXD] &&
		pe_out[SGP_PE_TXD] == $past(periph.serial_txd)) else $error("transmit pin wrong");
	a_rx_idle: assert property (!periph.serial_unit_enable |=> serial_rxd)
		else $error("receive not idle");
	a_timer_external_clock_off: assert property (periph.timer_prescaler_select != SGP_PS_EXT_CLK |=>
		!timer_external_clock) else $error("external clock leaks");
	a_spi_off: assert property (!periph.spi_unit_enable |=> spi_in == 3'h0 && spi_slave_select_n)
		else $error("spi inputs leak");
	a_ss_master: assert property (periph.spi_master_select |=> spi_slave_select_n)
		else $error("select in master");
	a_tch_drive: assert property (periph.tch_own[0] |=>
		pe_oe[SGP_PE_TCH_LO] == $past(periph.tch_out_en[0])) else $error("timer pin oe");
endmodule // sgp_ports_monitor

bind sgp_ports sgp_ports_monitor sgp_ports_monitor_inst (.clk_sys(clk_sys), .rst(rst),
	.bus_req(bus_req), .rdata(rdata), .periph(periph), .timer_external_clock(timer_external_clock),
	.serial_rxd(serial_rxd), .spi_in(spi_in), .spi_slave_select_n(spi_slave_select_n),
	.pe_out(pe_out), .pe_oe(pe_oe), .pf_oe(pf_oe), .pg_out(pg_out), .pg_oe(pg_oe));

/* dv/tb.sv */
// tb: register and pin tests of sgp_ports
// assumes board levels from sgp_pins_model; no random stimulus
`timescale 1ns/10ps
module tb;
	import sgp_pkg::*;
	logic clk_sys;
	logic rst;
	sgp_bus_req_t bus_req;
	sgp_periph_t periph;
	logic [7:0] rdata, pe_in, pe_out, pe_oe, pe_ext;
	logic [5:0] pf_in, pf_out, pf_oe, pf_ext;
	logic [3:0] pg_in, pg_out, pg_oe, pg_ext, tch_in;
	logic [2:0] spi_in;
	logic timer_external_clock, serial_rxd, spi_slave_select_n;
	int fail_count, comparisons, cycles;
	sgp_ports sgp_ports_inst (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rdata(rdata),
		.periph(periph), .tch_in(tch_in), .timer_external_clock(timer_external_clock),
		.serial_rxd(serial_rxd), .spi_in(spi_in), .spi_slave_select_n(spi_slave_select_n),
		.pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe), .pf_in(pf_in), .pf_out(pf_out),
		.pf_oe(pf_oe), .pg_in(pg_in), .pg_out(pg_out), .pg_oe(pg_oe));
	sgp_pins_model #(.W(8)) pins_e (.pin_out(pe_out), .pin_oe(pe_oe), .ext(pe_ext), .pin_in(pe_in));
	sgp_pins_model #(.W(6)) pins_f (.pin_out(pf_out), .pin_oe(pf_oe), .ext(pf_ext), .pin_in(pf_in));
	sgp_pins_model #(.W(4)) pins_g (.pin_out(pg_out), .pin_oe(pg_oe), .ext(pg_ext), .pin_in(pg_in));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// whole run needs under a hundred cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 chk(name, exp, rdata);
	endtask
	task automatic settle;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	initial begin
		rst = 1'b1;
		bus_req = '0;
		periph = '0;
		pe_ext = 8'h3C;
		pf_ext = 6'h15;
		pg_ext = 4'hA;
		cycles = 0;
		fail_count = 0;
		comparisons = 0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd(SGP_OFS_PORT_E_DIR, 8'h00, "dir_e");
		rd(SGP_OFS_PORT_F_DIR, 8'h00, "dir_f");
		rd(SGP_OFS_PORT_G_DIR, 8'h00, "dir_g");
		wr(SGP_OFS_PORT_G_DATA, 8'h05);
		rd(SGP_OFS_PORT_G_DATA, 8'h0A, "g_pin");
		wr(SGP_OFS_PORT_G_DIR, 8'h03);
		rd(SGP_OFS_PORT_G_DATA, 8'h09, "g_mix");
		chk("oe_g", 8'h03, {4'h0, pg_oe});
		chk("out_g", 8'h01, {4'h0, pg_out & 4'h3});
		wr(SGP_OFS_PORT_E_DATA, 8'hA5);
		wr(SGP_OFS_PORT_E_DIR, 8'h0F);
		rd(SGP_OFS_PORT_E_DATA, 8'h35, "e_mix");
		wr(SGP_OFS_PORT_F_DATA, 8'h2A);
		wr(SGP_OFS_PORT_F_DIR, 8'h07);
		rd(SGP_OFS_PORT_F_DATA, 8'h12, "f_mix");
		rd(8'h0B, 8'h00, "unmapped");
		// second reset: directions clear, latches survive
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(SGP_OFS_PORT_F_DIR, 8'h00, "dir_f2");
		wr(SGP_OFS_PORT_F_DIR, 8'h3F);
		wr(SGP_OFS_PORT_G_DIR, 8'h0F);
		rd(SGP_OFS_PORT_F_DATA, 8'h2A, "f_kept");
		rd(SGP_OFS_PORT_G_DATA, 8'h05, "g_kept");
		@(posedge clk_sys);
		pf_ext <= 6'h14;
		periph <= '{tch_own: 4'h1, tch_out_en: 4'h1, tch_out: 4'h1, timer_prescaler_select: 3'h7,
			serial_unit_enable: 1'b1, serial_txd: 1'b0, spi_unit_enable: 1'b1,
			spi_master_select: 1'b0, spi_out_en: 3'h7, spi_out: 3'h2};
		settle;
		chk("oe_e", 8'h14, pe_oe);
		chk("out_e", 8'h10, pe_out & 8'h14);
		chk("rxd", 8'h00, {7'h0, serial_rxd});
		chk("timer_external_clock", 8'h01, {7'h0, timer_external_clock});
		chk("tch_in", 8'h01, {4'h0, tch_in});
		chk("oe_f", 8'h3E, {2'h0, pf_oe});
		chk("out_f", 8'h04, {2'h0, pf_out & 6'h0E});
		chk("spi_in", 8'h02, {5'h0, spi_in});
		chk("ss_n", 8'h00, {7'h0, spi_slave_select_n});
		rd(SGP_OFS_PORT_F_DATA, 8'h2A, "f_owned");
		@(posedge clk_sys);
		periph.spi_master_select <= 1'b1;
		settle;
		chk("ss_m", 8'h01, {7'h0, spi_slave_select_n});
		@(posedge clk_sys);
		periph.spi_unit_enable <= 1'b0;
		periph.serial_unit_enable <= 1'b0;
		periph.timer_prescaler_select <= 3'h0;
		settle;
		chk("oe_f2", 8'h3F, {2'h0, pf_oe});
		chk("oe_e2", 8'h10, pe_oe);
		chk("rxd2", 8'h01, {7'h0, serial_rxd});
		chk("tclk2", 8'h00, {7'h0, timer_external_clock});
		test_done();
	end
endmodule // tb
